//--- hw/dual_timer_capture.sv
// two 16-bit timer/counters plus the capture mode of a third timer
// assumes: control bits are plain ports from the register logic outside;
// pins are asynchronous and are synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.svh"

module dual_timer_capture
    import timer_pkg::*;
(
    input wire logic clk_in,                      // system clock, 125 MHz
    input wire logic rst_n_in,                    // async reset, active low
    input wire logic [7:0] timer_mode_reg_in,     // mode, function, gate fields
    input wire logic unit_zero_run_in,            // run bit, unit zero
    input wire logic unit_one_run_in,             // run bit, unit one
    input wire logic unit_zero_turbo_sel_in,      // clock/4 for unit zero
    input wire logic unit_one_turbo_sel_in,       // clock/4 for unit one
    input wire logic third_timer_turbo_sel_in,    // clock/4 for third timer
    input wire logic third_timer_source_sel_in,   // 1 counts pin edges
    input wire logic third_timer_run_in,          // run bit, third timer
    input wire logic capture_reload_sel_in,       // 1 selects capture mode
    input wire logic external_capture_enable_in,  // arms the capture pin
    input wire logic capture_auto_clear_in,       // clear count after capture
    input wire logic unit_zero_count_input_in,    // count pin, unit zero
    input wire logic unit_one_count_input_in,     // count pin, unit one
    input wire logic third_timer_count_input_in,  // count pin, third timer
    input wire logic capture_input_pin_in,        // capture pin
    input wire logic ext_irq_pin_zero_in,         // gate pin, unit zero
    input wire logic ext_irq_pin_one_in,          // gate pin, unit one
    input wire logic unit_zero_irq_ack_in,        // unit zero interrupt served
    input wire logic unit_one_irq_ack_in,         // unit one interrupt served
    input wire logic tf2_clear_in,                // software clears overflow
    input wire logic third_timer_external_flag_clear_in,               // software clears ext flag
    input wire logic [7:0] wr_data_in,            // byte for count writes
    input wire logic wr_u0_lo_in,                 // write unit zero low byte
    input wire logic wr_u0_hi_in,                 // write unit zero high byte
    input wire logic wr_u1_lo_in,                 // write unit one low byte
    input wire logic wr_u1_hi_in,                 // write unit one high byte
    input wire logic wr_t2_lo_in,                 // write third timer low
    input wire logic wr_t2_hi_in,                 // write third timer high
    output logic [7:0] unit_zero_low_byte_out,    // count, unit zero low
    output logic [7:0] unit_zero_high_byte_out,   // count, unit zero high
    output logic [7:0] unit_one_low_byte_out,     // count, unit one low
    output logic [7:0] unit_one_high_byte_out,    // count, unit one high
    output logic [7:0] third_timer_low_byte_out,  // count, third low
    output logic [7:0] third_timer_high_byte_out, // count, third high
    output logic [7:0] capture_low_reg_out,       // captured low byte
    output logic [7:0] capture_high_reg_out,      // captured high byte
    output logic unit_zero_overflow_flag_out,     // overflow, unit zero
    output logic unit_one_overflow_flag_out,      // overflow, unit one
    output logic third_timer_overflow_flag_out,   // overflow, third timer
    output logic third_timer_external_flag_out,   // capture event flag
    output logic third_timer_irq_out              // third timer request
);
    core_state_t q;
    core_state_t d;
    logic c3;
    logic c4;
    logic slow;
    logic fall0;
    logic fall1;
    logic fall2;
    logic fall_ex;
    logic gate_lvl0;
    logic gate_lvl1;
    mode_t m0;
    mode_t m1;
    logic en0;
    logic en1;
    logic tick0;
    logic tick0_hi;
    logic tick1;
    logic tick2;
    logic cap_ev;
    logic [16:0] r0;
    logic [16:0] r1;
    logic [8:0] s8_lo;
    logic [8:0] s8_hi;
    logic [16:0] s2;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // one count step per mode: {overflow, high, low}
    function automatic logic [16:0] advance(input mode_t m, input logic [7:0] hi, input logic [7:0] lo);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        case (m)
            MODE_13BIT: advance = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
            MODE_16BIT: advance = s16;
            MODE_RELOAD: advance = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
            default: advance = {1'b0, hi, lo};
        endcase
    endfunction

    // count strobe: pin edge or divided clock, always landing on C3
    function automatic logic base_tick(input logic ext, input logic turbo, input logic fall,
                                       input logic c3s, input logic slows);
        base_tick = ext ? fall : (turbo ? c3s : slows);
    endfunction

    // ------------------------------------------------------------
    // phase generator and pin samplers
    // ------------------------------------------------------------
    machine_phase u_phase (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .c3_out(c3),
        .c4_out(c4),
        .slow_out(slow)
    );

    pin_edge_sampler u_t0 (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(unit_zero_count_input_in),
        .c3_in(c3), .c4_in(c4), .level_out(), .fall_out(fall0));
    pin_edge_sampler u_t1 (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(unit_one_count_input_in),
        .c3_in(c3), .c4_in(c4), .level_out(), .fall_out(fall1));
    pin_edge_sampler u_t2 (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(third_timer_count_input_in),
        .c3_in(c3), .c4_in(c4), .level_out(), .fall_out(fall2));
    pin_edge_sampler u_ex (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(capture_input_pin_in),
        .c3_in(c3), .c4_in(c4), .level_out(), .fall_out(fall_ex));
    pin_edge_sampler u_g0 (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(ext_irq_pin_zero_in),
        .c3_in(c3), .c4_in(c4), .level_out(gate_lvl0), .fall_out());
    pin_edge_sampler u_g1 (.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(ext_irq_pin_one_in),
        .c3_in(c3), .c4_in(c4), .level_out(gate_lvl1), .fall_out());

    // ------------------------------------------------------------
    // enables and ticks
    // ------------------------------------------------------------
    // mode fields
    assign m0 = mode_t'(timer_mode_reg_in[`TIMER_MODE_REG_MODE0_MSB:`TIMER_MODE_REG_MODE0_LSB]);
    assign m1 = mode_t'(timer_mode_reg_in[`TIMER_MODE_REG_MODE1_MSB:`TIMER_MODE_REG_MODE1_LSB]);
    assign en0 = unit_zero_run_in && (!timer_mode_reg_in[`TIMER_MODE_REG_GATE0_BIT] || gate_lvl0);
    assign en1 = ((m0 == MODE_SPLIT) || unit_one_run_in) && (!timer_mode_reg_in[`TIMER_MODE_REG_GATE1_BIT] || gate_lvl1);
    assign tick0 = en0 && base_tick(timer_mode_reg_in[`TIMER_MODE_REG_CT0_BIT], q.turbo0, fall0, c3, slow);
    assign tick0_hi = (m0 == MODE_SPLIT) && unit_one_run_in && base_tick(1'b0, q.turbo0, 1'b0, c3, slow);
    assign tick1 = en1 && (m1 != MODE_SPLIT)
                   && base_tick(timer_mode_reg_in[`TIMER_MODE_REG_CT1_BIT], q.turbo1, fall1, c3, slow);
    assign tick2 = third_timer_run_in && capture_reload_sel_in
                   && base_tick(third_timer_source_sel_in, q.turbo2, fall2, c3, slow);
    assign cap_ev = capture_reload_sel_in && external_capture_enable_in && fall_ex;

    assign r0 = advance(m0, q.th0, q.tl0);
    assign r1 = advance(m1, q.th1, q.tl1);
    assign s8_lo = {1'b0, q.tl0} + 9'h001;
    assign s8_hi = {1'b0, q.th0} + 9'h001;
    assign s2 = {1'b0, q.th2, q.tl2} + 17'h00001;

    // ------------------------------------------------------------
    // next state: counts, flags, writes (writes win over counting)
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.turbo0 = unit_zero_turbo_sel_in;
        d.turbo1 = unit_one_turbo_sel_in;
        d.turbo2 = third_timer_turbo_sel_in;
        d.tf0 = q.tf0 && !unit_zero_irq_ack_in;
        d.tf1 = q.tf1 && !unit_one_irq_ack_in;
        d.tf2 = q.tf2 && !tf2_clear_in;
        d.third_timer_external_flag = q.third_timer_external_flag && !third_timer_external_flag_clear_in;
        if (m0 == MODE_SPLIT) begin
            if (tick0) begin
                d.tl0 = s8_lo[7:0];
                d.tf0 = d.tf0 || s8_lo[8];
            end
            if (tick0_hi) begin
                d.th0 = s8_hi[7:0];
                d.tf1 = d.tf1 || s8_hi[8];
            end
        end else if (tick0) begin
            {d.th0, d.tl0} = r0[15:0];
            d.tf0 = d.tf0 || r0[16];
        end
        if (tick1) begin
            {d.th1, d.tl1} = r1[15:0];
            d.tf1 = d.tf1 || (r1[16] && (m0 != MODE_SPLIT));
        end
        if (tick2) begin
            {d.th2, d.tl2} = s2[15:0];
            d.tf2 = d.tf2 || s2[16];
        end
        if (cap_ev) begin
            d.cap_lo = q.tl2;
            d.cap_hi = q.th2;
            d.third_timer_external_flag = 1'b1;
            if (capture_auto_clear_in) begin
                d.tl2 = `BYTE_RESET;
                d.th2 = `BYTE_RESET;
            end
        end
        if (wr_u0_lo_in) d.tl0 = wr_data_in;
        if (wr_u0_hi_in) d.th0 = wr_data_in;
        if (wr_u1_lo_in) d.tl1 = wr_data_in;
        if (wr_u1_hi_in) d.th1 = wr_data_in;
        if (wr_t2_lo_in) d.tl2 = wr_data_in;
        if (wr_t2_hi_in) d.th2 = wr_data_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign unit_zero_low_byte_out = q.tl0;
    assign unit_zero_high_byte_out = q.th0;
    assign unit_one_low_byte_out = q.tl1;
    assign unit_one_high_byte_out = q.th1;
    assign third_timer_low_byte_out = q.tl2;
    assign third_timer_high_byte_out = q.th2;
    assign capture_low_reg_out = q.cap_lo;
    assign capture_high_reg_out = q.cap_hi;
    assign unit_zero_overflow_flag_out = q.tf0;
    assign unit_one_overflow_flag_out = q.tf1;
    assign third_timer_overflow_flag_out = q.tf2;
    assign third_timer_external_flag_out = q.third_timer_external_flag;
    assign third_timer_irq_out = q.tf2 || q.third_timer_external_flag;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic no_wr0;
    logic no_wr2;
    assign no_wr0 = !wr_u0_lo_in && !wr_u0_hi_in;
    assign no_wr2 = !wr_t2_lo_in && !wr_t2_hi_in;

    a_std_spacing: assert property (slow |-> ##`STD_TICK_CLOCKS slow)
        else $error("divide-by-twelve tick spacing wrong");
    a_count_at_c3: assert property (
        (tick0 || tick1 || tick2) |-> c3)
        else $error("count advanced outside C3");
    a_mode0_wrap: assert property (
        (m0 == MODE_13BIT) && tick0 && no_wr0 && ({q.th0, q.tl0[4:0]} == `M13_MAX)
        |=> q.tf0 && (q.th0 == `BYTE_RESET) && (q.tl0[4:0] == 5'h00))
        else $error("mode 0 wrap missed");
    a_mode1_wrap: assert property (
        (m0 == MODE_16BIT) && tick0 && no_wr0 && ({q.th0, q.tl0} == `W16_MAX)
        |=> q.tf0 && ({q.th0, q.tl0} == 16'h0000))
        else $error("mode 1 wrap missed");
    a_mode2_reload: assert property (
        (m0 == MODE_RELOAD) && tick0 && no_wr0 && (q.tl0 == `BYTE_MAX)
        |=> q.tf0 && (q.tl0 == $past(q.th0)) && $stable(q.th0))
        else $error("mode 2 reload wrong");
    a_gate_block: assert property (
        !en0 && no_wr0 && (m0 != MODE_SPLIT) |=> $stable({q.th0, q.tl0}))
        else $error("unit zero counted while gated off");
    a_unit1_hold: assert property (
        (m1 == MODE_SPLIT) && !wr_u1_lo_in && !wr_u1_hi_in |=> $stable({q.th1, q.tl1}))
        else $error("unit one moved in mode 3");

    sequence capture_taken;
        cap_ev && no_wr2 ##1 (q.third_timer_external_flag && ({q.cap_hi, q.cap_lo} == $past({q.th2, q.tl2})));
    endsequence

    a_capture_copy: assert property (cap_ev && no_wr2 |-> capture_taken)
        else $error("capture copy or flag missing");
    a_auto_clear: assert property (
        cap_ev && capture_auto_clear_in && no_wr2 |=> ({q.th2, q.tl2} == 16'h0000))
        else $error("count not cleared after capture");
    a_flag_keep: assert property (
        q.tf2 && !tf2_clear_in |=> q.tf2)
        else $error("overflow flag dropped without clear");

endmodule
`default_nettype wire

//--- hw/timer_defines.svh
// field positions, reset values and machine-cycle counts for the timer block
// assumes: included by the timer design files by its bare name
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ------------------------------------------------------------
// timer mode register field positions
// ------------------------------------------------------------
`define TIMER_MODE_REG_MODE0_LSB 0
`define TIMER_MODE_REG_MODE0_MSB 1
`define TIMER_MODE_REG_CT0_BIT 2
`define TIMER_MODE_REG_GATE0_BIT 3
`define TIMER_MODE_REG_MODE1_LSB 4
`define TIMER_MODE_REG_MODE1_MSB 5
`define TIMER_MODE_REG_CT1_BIT 6
`define TIMER_MODE_REG_GATE1_BIT 7

// ------------------------------------------------------------
// timing: a machine cycle is four clocks (C1..C4)
// ------------------------------------------------------------
`define MC_CLOCKS 4
`define STD_TICK_LAST_MC 2'h2
`define STD_TICK_CLOCKS 12

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define TURBO_RESET 1'b0
`define BYTE_RESET 8'h00
`define BYTE_MAX 8'hFF
`define M13_MAX 13'h1FFF
`define W16_MAX 16'hFFFF

`endif

//--- hw/timer_pkg.sv
// types shared by the timer design files
// assumes: compiled before every timer module
package timer_pkg;

    // machine-cycle states
    typedef enum logic [1:0] {
        PH_C1 = 2'b00,
        PH_C2 = 2'b01,
        PH_C3 = 2'b10,
        PH_C4 = 2'b11
    } phase_t;

    // operating modes of units zero and one
    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } mode_t;

    typedef struct packed {
        phase_t phase;
        logic [1:0] mc_cnt;
    } phase_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic smp;
        logic pend;
    } edge_state_t;

    typedef struct packed {
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic [7:0] tl2;
        logic [7:0] th2;
        logic [7:0] cap_lo;
        logic [7:0] cap_hi;
        logic tf0;
        logic tf1;
        logic tf2;
        logic third_timer_external_flag;
        logic turbo0;
        logic turbo1;
        logic turbo2;
    } core_state_t;

endpackage

//--- hw/machine_phase.sv
// machine-cycle phase generator: C3/C4 strobes and the divide-by-twelve tick
// assumes: free-running system clock, nothing else
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.svh"

module machine_phase
    import timer_pkg::*;
(
    input wire logic clk_in,    // system clock
    input wire logic rst_n_in,  // async reset, active low
    output logic c3_out,        // one clock at state C3
    output logic c4_out,        // one clock at state C4
    output logic slow_out       // C3 of every third machine cycle
);
    phase_state_t q;
    phase_state_t d;

    // ------------------------------------------------------------
    // phase walk and machine-cycle divider
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        case (q.phase)
            PH_C1: d.phase = PH_C2;
            PH_C2: d.phase = PH_C3;
            PH_C3: d.phase = PH_C4;
            PH_C4: begin
                d.phase = PH_C1;
                d.mc_cnt = (q.mc_cnt == `STD_TICK_LAST_MC) ? 2'h0 : q.mc_cnt + 2'h1;
            end
            default: d.phase = PH_C1;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // strobes straight from state flops
    assign c3_out = (q.phase == PH_C3);
    assign c4_out = (q.phase == PH_C4);
    assign slow_out = (q.phase == PH_C3) && (q.mc_cnt == `STD_TICK_LAST_MC);

endmodule
`default_nettype wire

//--- hw/pin_edge_sampler.sv
// pin synchroniser with per-machine-cycle sampling and falling-edge detect
// assumes: c3/c4 strobes from the phase generator on the same clock
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sampler
    import timer_pkg::*;
(
    input wire logic clk_in,    // system clock
    input wire logic rst_n_in,  // async reset, active low
    input wire logic pin_in,    // asynchronous pin
    input wire logic c3_in,     // C3 strobe
    input wire logic c4_in,     // C4 strobe
    output logic level_out,     // synchronised pin level
    output logic fall_out       // one clock at C3 after a fall
);
    edge_state_t q;
    edge_state_t d;

    // ------------------------------------------------------------
    // sample at C4, report at the following C3
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        if (c3_in) begin
            d.pend = 1'b0;
        end
        if (c4_in) begin
            d.smp = q.s2;
            d.pend = q.smp && !q.s2;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_out = q.s2;
    assign fall_out = q.pend && c3_in;

    sequence hi_then_lo;
        (c4_in && q.s2) ##4 (c4_in && !q.s2);
    endsequence

    a_fall_detect: assert property (
        @(posedge clk_in) disable iff (!rst_n_in) hi_then_lo |-> ##3 fall_out)
        else $error("falling edge not reported at next C3");

endmodule
`default_nettype wire

//--- testbench/pin_source.sv
// model of the external pins: count sources, capture pin and gate pins
// assumes: bench clock at 125 MHz, levels change on its falling edge
`timescale 1ns/100ps
`default_nettype none

module pin_source (
    input wire logic clk_in,       // bench clock
    output logic [3:0] fall_out,   // count pins 0..2, capture pin at 3
    output logic [1:0] gate_out    // gate pins of units zero and one
);
    // idle high so no edge is seen before a pulse is asked for
    initial begin
        fall_out = 4'hF;
        gate_out = 2'h3;
    end

    // gate pin levels, driven only from this model
    task automatic set_gate(input logic [1:0] v);
        gate_out = v;
    endtask

    // twelve clocks each level
    // one fall per 24 clocks, a third of the fastest rate of one per 8 clocks that the C4 sampling can see
    task automatic pulses(input int sel, input int n);
        repeat (n) begin
            repeat (12) @(negedge clk_in);
            fall_out[sel] = 1'b0;
            repeat (12) @(negedge clk_in);
            fall_out[sel] = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_dual_timer_capture.sv
// self-checking bench for the timer block and its capture timer
// assumes: pins come from pin_source, control bits driven here
`timescale 1ns/100ps
`default_nettype none

module tb_dual_timer_capture;
    import timer_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] timer_mode_reg = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [2:0] run = 3'h0;
    logic [2:0] turbo = 3'h0;
    logic [5:0] wr = 6'h00;
    logic [3:0] clr = 4'h0;  // two acks, then the two software clears
    logic cap_en = 1'b0;
    logic auto_clr = 1'b0;
    logic src2 = 1'b0;
    logic csel = 1'b1;
    logic [7:0] u0l, u0h, u1l, u1h, t2l, t2h, cl, ch;
    logic [3:0] fl;
    logic [3:0] pin;
    logic [1:0] gate;
    logic irq;
    int errors = 0;
    int n_checks = 0;

    pin_source i_pin_source (.clk_in(clk_in), .fall_out(pin), .gate_out(gate));

    // only capture mode is built; csel low must stop the third timer
    dual_timer_capture i_dual_timer_capture (
        .clk_in(clk_in), .rst_n_in(rst_n), .timer_mode_reg_in(timer_mode_reg),
        .unit_zero_run_in(run[0]), .unit_one_run_in(run[1]), .third_timer_run_in(run[2]),
        .unit_zero_turbo_sel_in(turbo[0]), .unit_one_turbo_sel_in(turbo[1]),
        .third_timer_turbo_sel_in(turbo[2]), .third_timer_source_sel_in(src2),
        .capture_reload_sel_in(csel), .external_capture_enable_in(cap_en),
        .capture_auto_clear_in(auto_clr), .unit_zero_count_input_in(pin[0]),
        .unit_one_count_input_in(pin[1]), .third_timer_count_input_in(pin[2]),
        .capture_input_pin_in(pin[3]), .ext_irq_pin_zero_in(gate[0]), .ext_irq_pin_one_in(gate[1]),
        .unit_zero_irq_ack_in(clr[0]), .unit_one_irq_ack_in(clr[1]),
        .tf2_clear_in(clr[2]), .third_timer_external_flag_clear_in(clr[3]), .wr_data_in(wd),
        .wr_u0_lo_in(wr[0]), .wr_u0_hi_in(wr[1]), .wr_u1_lo_in(wr[2]),
        .wr_u1_hi_in(wr[3]), .wr_t2_lo_in(wr[4]), .wr_t2_hi_in(wr[5]),
        .unit_zero_low_byte_out(u0l), .unit_zero_high_byte_out(u0h),
        .unit_one_low_byte_out(u1l), .unit_one_high_byte_out(u1h),
        .third_timer_low_byte_out(t2l), .third_timer_high_byte_out(t2h),
        .capture_low_reg_out(cl), .capture_high_reg_out(ch),
        .unit_zero_overflow_flag_out(fl[0]), .unit_one_overflow_flag_out(fl[1]),
        .third_timer_overflow_flag_out(fl[2]), .third_timer_external_flag_out(fl[3]),
        .third_timer_irq_out(irq)
    );

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // two byte writes, low strobe k then high strobe k+1
    task automatic put16(input int k, input logic [15:0] v);
        @(negedge clk_in);
        wd = v[7:0];
        wr[k] = 1'b1;
        @(negedge clk_in);
        wr[k] = 1'b0;
        wd = v[15:8];
        wr[k+1] = 1'b1;
        @(negedge clk_in);
        wr[k+1] = 1'b0;
    endtask

    task automatic clear(input int k);
        @(negedge clk_in);
        clr[k] = 1'b1;
        @(negedge clk_in);
        clr[k] = 1'b0;
    endtask

    // a flag that never rises ends the run as a failure
    task automatic wait_flag(input int k);
        int i;
        for (i = 0; i < 3000 && fl[k] !== 1'b1; i++) @(negedge clk_in);
        if (i == 3000) begin
            errors++;
            wrap_up();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_rate();
        logic [15:0] a;
        chk({u0h, u0l}, 16'h0000);
        chk({12'h000, fl}, 16'h0000);
        timer_mode_reg = 8'h01;
        run[0] = 1'b1;
        tick(4);
        a = {u0h, u0l};
        tick(48);
        chk({u0h, u0l} - a, 16'h0004);
        turbo[0] = 1'b1;
        tick(4);
        a = {u0h, u0l};
        tick(48);
        chk({u0h, u0l} - a, 16'h000C);
        run[0] = 1'b0;
    endtask

    // 16-bit wrap, then a 13-bit wrap keeping the ignored bits
    task automatic s_wrap();
        put16(0, 16'hFFFF);
        run[0] = 1'b1;
        wait_flag(0);
        chk({u0h, u0l}, 16'h0000);
        run[0] = 1'b0;
        clear(0);
        chk({15'h0000, fl[0]}, 16'h0000);
        timer_mode_reg = 8'h00;
        put16(0, 16'hFFFF);
        run[0] = 1'b1;
        wait_flag(0);
        chk({u0h, u0l}, 16'h00E0);
        run[0] = 1'b0;
        clear(0);
    endtask

    task automatic s_reload();
        timer_mode_reg = 8'h20;
        turbo[1] = 1'b1;
        put16(2, 16'hA5FF);
        run[1] = 1'b1;
        wait_flag(1);
        chk({u1h, u1l}, 16'hA5A5);
        run[1] = 1'b0;
        clear(1);
    endtask

    // unit one frozen; its run bit now drives unit zero's high byte
    task automatic s_split();
        logic [15:0] a;
        logic [15:0] b;
        timer_mode_reg = 8'h33;
        run = 3'b010;
        tick(4);
        a = {u0h, u0l};
        b = {u1h, u1l};
        tick(48);
        chk({u0h, u0l} - a, 16'h0C00);
        chk({u1h, u1l}, b);
        run = 3'b000;
        clear(1);
    endtask

    task automatic s_gate();
        timer_mode_reg = 8'h0D;
        put16(0, 16'h0000);
        i_pin_source.set_gate(2'b10);
        run[0] = 1'b1;
        i_pin_source.pulses(0, 2);
        tick(24);
        chk({u0h, u0l}, 16'h0000);
        i_pin_source.set_gate(2'b11);
        tick(4);
        i_pin_source.pulses(0, 3);
        tick(24);
        chk({u0h, u0l}, 16'h0003);
        run[0] = 1'b0;
    endtask

    task automatic s_capture();
        turbo[2] = 1'b1;
        put16(4, 16'hFFFF);
        run[2] = 1'b1;
        wait_flag(2);
        chk({t2h, t2l}, 16'h0000);
        chk({15'h0000, irq}, 16'h0001);
        clear(2);
        chk({14'h0000, fl[3:2]}, 16'h0000);
        cap_en = 1'b1;
        fork
            i_pin_source.pulses(3, 1);
            wait_flag(3);
        join_any
        chk({t2h, t2l} - {ch, cl}, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        tick(16);
        clear(3);
        auto_clr = 1'b1;
        fork
            i_pin_source.pulses(3, 1);
            wait_flag(3);
        join_any
        chk({t2h, t2l}, 16'h0000);
        tick(16);
        // count pin falls instead of clock, then refuse with capture off
        src2 = 1'b1;
        put16(4, 16'h0000);
        i_pin_source.pulses(2, 2);
        tick(24);
        chk({t2h, t2l}, 16'h0002);
        csel = 1'b0;
        i_pin_source.pulses(2, 1);
        tick(24);
        chk({t2h, t2l}, 16'h0002);
    endtask

    initial begin
        repeat (20) @(negedge clk_in);
        rst_n = 1'b1;
        tick(2);
        s_rate();
        s_wrap();
        s_reload();
        s_split();
        s_gate();
        s_capture();
        wrap_up();
    end
endmodule
`default_nettype wire
